// ### src/timer_defines.svh
// Constants for the dual timer: register map, field positions, codes.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------------
// Register word addresses (byte address bits 7:2).
// ----------------------------------------------------------------------
`define TMR_ADR_PRESCALE 6'h00
`define TMR_ADR_CLKSRC 6'h01
`define TMR_ADR_CNT_ONE 6'h02
`define TMR_ADR_CNT_TWO 6'h03
`define TMR_ADR_REG_A 6'h04
`define TMR_ADR_REG_B 6'h05
`define TMR_ADR_MODE_CTRL 6'h06
`define TMR_ADR_IRQ_CTRL 6'h07
`define TMR_ADR_IRQ_CLEAR 6'h08
`define TMR_ADR_IRQ_LINES 6'h09

// ----------------------------------------------------------------------
// Field positions and widths.
// ----------------------------------------------------------------------
`define TMR_PS_W 5
`define TMR_CNT_W 16
`define TMR_CS_W 3
`define TMR_CS1_LSB 0
`define TMR_CS2_LSB 3
`define TMR_MC_MODE_LSB 0
`define TMR_MC_A_EDGE 2
`define TMR_MC_B_EDGE 3
`define TMR_MC_A_EN 4
`define TMR_MC_B_EN 5
`define TMR_MC_A_OUT 6
`define TMR_IC_PEND_LSB 0
`define TMR_IC_IEN_LSB 4

// ----------------------------------------------------------------------
// Codes, reset values and fixed values.
// ----------------------------------------------------------------------
`define TMR_MODE_PWM 2'h0
`define TMR_MODE_CAPTURE 2'h1
`define TMR_MODE_DUAL 2'h2
`define TMR_MODE_SINGLE 2'h3
`define TMR_CS_NONE 3'h0
`define TMR_CS_PRESCALED 3'h1
`define TMR_CS_EVENT 3'h2
`define TMR_CS_ACCUM 3'h3
`define TMR_CS_SLOW 3'h4
`define TMR_CNT_PRESET 16'hFFFF
`define TMR_CNT_ZERO 16'h0000
`define TMR_IRQ_U1_LINE_ONE 8'h0D
`define TMR_IRQ_U1_LINE_TWO 8'h0C
`define TMR_IRQ_U2_LINE_ONE 8'h0B
`define TMR_IRQ_U2_LINE_TWO 8'h0A

`endif

// ### src/timer_pkg.sv
// Types shared by the dual timer modules.
`default_nettype none
`include "timer_defines.svh"

package timer_pkg;

    // State of the prescaler.
    typedef struct packed {
        logic [`TMR_PS_W-1:0] count;
    } prescale_state_s;

    // State of the timer unit.
    typedef struct packed {
        logic [`TMR_PS_W-1:0] prescale;
        logic [`TMR_CS_W-1:0] cs_one;
        logic [`TMR_CS_W-1:0] cs_two;
        logic [`TMR_CNT_W-1:0] counter_one;
        logic [`TMR_CNT_W-1:0] counter_two;
        logic [`TMR_CNT_W-1:0] reg_a;
        logic [`TMR_CNT_W-1:0] reg_b;
        logic [1:0] mode;
        logic a_edge;
        logic b_edge;
        logic a_en;
        logic b_en;
        logic a_out;
        logic [3:0] pending;
        logic [3:0] irq_en;
        logic reload_b;
        logic pin_a_prev;
        logic pin_b_prev;
        logic slow_prev;
        logic ack;
        logic [31:0] rdata;
    } timer_state_s;

endpackage : timer_pkg

`default_nettype wire

// ### src/prescale_tick.sv
// Prescaler that pulses once every div_i+1 clocks.
`default_nettype none
`include "timer_defines.svh"

module prescale_tick
    import timer_pkg::*;
(
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; freezes state when low.
    input wire logic [`TMR_PS_W-1:0] div_i, // Divide value minus one.
    output logic tick_o // One-cycle pulse at the divided rate.
);

    prescale_state_s s_reg;
    prescale_state_s s_next;

    // A value of zero ticks every clock, 31 every 32nd clock.
    assign tick_o = ce_i && (s_reg.count >= div_i);

    // Count up and restart after the tick.
    always_comb begin
        s_next = s_reg;
        if (tick_o) begin
            s_next.count = '0;
        end else begin
            s_next.count = s_reg.count + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

endmodule : prescale_tick

`default_nettype wire

// ### src/dual_timer.sv
// Dual 16-bit multi-function timer with a classic Wishbone slave.
//
// What this block does
// - A, B, C share line one; D drives two.
// - Each source has enable and pending bit.
// - Unit one lines 13/12, unit two 11/10.
// - Mode 1: reloads A/B, counter two underflow D.
// - Mode 2: captures A/B, underflows C and D.
// - Mode 3: reload A sets A, counter-two reload D.
// - Mode 4: reload A, capture B, underflow D.
// - Enabled pin A toggles on counter-one underflow.
// - Pin A starts at the output-data bit.
// - Toggle output only in modes 1, 3, 4.
// - Mode 2 pin-A edge captures, optionally presets.
// - Modes 2 and 4: pin-B edge captures counter, optionally presets it.
// - Preset loads all ones after the capture.
// - Modes 1 and 3: pin B is clock input.
// - Prescaler holds five bits, cleared by reset.
// - Prescaled clock divides by value plus one.
// - Three-bit clock source field per counter.
// - Source codes 1 to 4 start counter; 0 and 5 to 7 stop.
// - Reset clears clock sources, stopping both counters.
// - Slow-clock code counts the external slow clock.
// - Two-bit mode field selects modes 1 to 4.
// - Events set pending; only clear register clears.
`default_nettype none
`include "timer_defines.svh"

module dual_timer
    import timer_pkg::*;
#(
    parameter bit UNIT_TWO = 1'b0 // Second unit's line numbers.
) (
    input wire logic clk_i, // System clock, 40 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; freezes all state when low.
    input wire logic cyc_i, // Wishbone cycle.
    input wire logic stb_i, // Wishbone strobe.
    input wire logic we_i, // Wishbone write enable.
    input wire logic [7:0] adr_i, // Wishbone byte address.
    input wire logic [3:0] sel_i, // Wishbone byte lane selects.
    input wire logic [31:0] dat_i, // Wishbone write data.
    output logic [31:0] dat_o, // Wishbone read data.
    output logic ack_o, // Wishbone acknowledge.
    input wire logic pin_a_i, // Level on timer pin A.
    output logic pin_a_o, // Drive level for timer pin A.
    output logic pin_a_oe_n_o, // Pin A output enable, low while driving.
    input wire logic pin_b_i, // Level on timer pin B.
    input wire logic slow_clk_i, // External slow clock, sampled.
    output logic irq_one_o, // Interrupt line one (sources A, B, C).
    output logic irq_two_o // Interrupt line two (source D).
);

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------

    // True when a pin moved in the chosen direction.
    function automatic logic edge_seen(input logic prev, input logic cur,
                                       input logic rising);
        edge_seen = rising ? (cur && !prev) : (!cur && prev);
    endfunction : edge_seen

    // Count enable for one counter from its clock-source code.
    function automatic logic clk_tick(input logic [`TMR_CS_W-1:0] cs,
                                      input logic pin_b_ok,
                                      input logic ps_tick,
                                      input logic b_evt,
                                      input logic b_lvl_ok,
                                      input logic slow_evt);
        clk_tick = 1'b0;
        case (cs)
            `TMR_CS_PRESCALED: clk_tick = ps_tick;
            `TMR_CS_EVENT: clk_tick = pin_b_ok && b_evt;
            `TMR_CS_ACCUM: clk_tick = pin_b_ok && b_lvl_ok && ps_tick;
            `TMR_CS_SLOW: clk_tick = slow_evt;
            default: clk_tick = 1'b0;
        endcase
    endfunction : clk_tick

    // Merge a write into a 16-bit register by byte lane.
    function automatic logic [`TMR_CNT_W-1:0] put16(
        input logic [`TMR_CNT_W-1:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel);
        put16 = old;
        if (sel[0]) begin
            put16[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            put16[15:8] = wd[15:8];
        end
    endfunction : put16

    // ------------------------------------------------------------------
    // State and derived signals.
    // ------------------------------------------------------------------
    timer_state_s s_reg;
    timer_state_s s_next;
    logic ps_tick;
    logic is_pwm;
    logic is_cap;
    logic is_dual;
    logic is_single;
    logic pin_b_clk_ok;
    logic a_evt;
    logic b_evt;
    logic slow_evt;
    logic tick_one;
    logic tick_two;
    logic uf_one;
    logic uf_two;
    logic a_drive;
    logic [3:0] events;
    logic [7:0] line_one_num;
    logic [7:0] line_two_num;

    // Prescaler shared by both counters.
    prescale_tick u_prescale (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .div_i (s_reg.prescale),
        .tick_o (ps_tick)
    );

    // Mode decode.
    assign is_pwm = (s_reg.mode == `TMR_MODE_PWM);
    assign is_cap = (s_reg.mode == `TMR_MODE_CAPTURE);
    assign is_dual = (s_reg.mode == `TMR_MODE_DUAL);
    assign is_single = (s_reg.mode == `TMR_MODE_SINGLE);

    // Pin B is a clock input only in the two timer modes.
    assign pin_b_clk_ok = is_pwm || is_dual;

    // Edge events on the pins and the slow clock.
    assign a_evt = edge_seen(s_reg.pin_a_prev, pin_a_i, s_reg.a_edge);
    assign b_evt = edge_seen(s_reg.pin_b_prev, pin_b_i, s_reg.b_edge);
    assign slow_evt = slow_clk_i && !s_reg.slow_prev;

    // Count enables; a zero source code holds a counter still.
    assign tick_one = clk_tick(s_reg.cs_one, pin_b_clk_ok, ps_tick, b_evt,
                               pin_b_i == s_reg.b_edge, slow_evt);
    assign tick_two = clk_tick(s_reg.cs_two, pin_b_clk_ok, ps_tick, b_evt,
                               pin_b_i == s_reg.b_edge, slow_evt);

    // Underflow is a tick while the count is zero.
    assign uf_one = tick_one && (s_reg.counter_one == `TMR_CNT_ZERO);
    assign uf_two = tick_two && (s_reg.counter_two == `TMR_CNT_ZERO);

    // Interrupt source events per mode.
    assign events[0] = ((is_pwm && !s_reg.reload_b) && uf_one)
                       || (is_cap && a_evt)
                       || ((is_dual || is_single) && uf_one);
    assign events[1] = ((is_pwm && s_reg.reload_b) && uf_one)
                       || ((is_cap || is_single) && b_evt);
    assign events[2] = is_cap && uf_one;
    assign events[3] = uf_two;

    // Pin A drives only when enabled outside capture mode.
    assign a_drive = s_reg.a_en && !is_cap;

    // Line numbers for this unit.
    assign line_one_num = UNIT_TWO ? `TMR_IRQ_U2_LINE_ONE : `TMR_IRQ_U1_LINE_ONE;
    assign line_two_num = UNIT_TWO ? `TMR_IRQ_U2_LINE_TWO : `TMR_IRQ_U1_LINE_TWO;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        logic wr;
        logic [3:0] clr;
        logic [3:0] sw_set;
        wr = 1'b0;
        clr = 4'h0;
        sw_set = 4'h0;
        s_next = s_reg;
        s_next.pin_a_prev = pin_a_i;
        s_next.pin_b_prev = pin_b_i;
        s_next.slow_prev = slow_clk_i;

        // Counter one: count, reload or wrap on underflow.
        if (tick_one) begin
            if (uf_one) begin
                if (is_pwm) begin
                    s_next.counter_one = s_reg.reload_b ? s_reg.reg_b : s_reg.reg_a;
                    s_next.reload_b = !s_reg.reload_b;
                end else if (is_cap) begin
                    s_next.counter_one = `TMR_CNT_PRESET;
                end else begin
                    s_next.counter_one = s_reg.reg_a;
                end
            end else begin
                s_next.counter_one = s_reg.counter_one - 1'b1;
            end
        end

        // Counter two: reloads from register B only in dual mode.
        if (tick_two) begin
            if (uf_two && is_dual) begin
                s_next.counter_two = s_reg.reg_b;
            end else begin
                s_next.counter_two = s_reg.counter_two - 1'b1;
            end
        end

        // Pin A toggle on each counter-one underflow.
        if (uf_one && a_drive) begin
            s_next.a_out = !s_reg.a_out;
        end

        // Capture from pin A, then optional preset.
        if (is_cap && a_evt) begin
            s_next.reg_a = s_reg.counter_one;
            if (s_reg.a_en) begin
                s_next.counter_one = `TMR_CNT_PRESET;
            end
        end

        // Capture from pin B into register B, then optional preset.
        if (is_cap && b_evt) begin
            s_next.reg_b = s_reg.counter_one;
            if (s_reg.b_en) begin
                s_next.counter_one = `TMR_CNT_PRESET;
            end
        end else if (is_single && b_evt) begin
            s_next.reg_b = s_reg.counter_two;
            if (s_reg.b_en) begin
                s_next.counter_two = `TMR_CNT_PRESET;
            end
        end

        // Bus handshake: ack one cycle after the request.
        s_next.ack = cyc_i && stb_i && !s_reg.ack;
        wr = cyc_i && stb_i && we_i && s_reg.ack;

        // Read data is registered to stand with ack.
        s_next.rdata = 32'h0000_0000;
        if (cyc_i && stb_i && !s_reg.ack && !we_i) begin
            unique case (adr_i[7:2])
                `TMR_ADR_PRESCALE: s_next.rdata[`TMR_PS_W-1:0] = s_reg.prescale;
                `TMR_ADR_CLKSRC: s_next.rdata[5:0] = {s_reg.cs_two, s_reg.cs_one};
                `TMR_ADR_CNT_ONE: s_next.rdata[15:0] = s_reg.counter_one;
                `TMR_ADR_CNT_TWO: s_next.rdata[15:0] = s_reg.counter_two;
                `TMR_ADR_REG_A: s_next.rdata[15:0] = s_reg.reg_a;
                `TMR_ADR_REG_B: s_next.rdata[15:0] = s_reg.reg_b;
                `TMR_ADR_MODE_CTRL: s_next.rdata[6:0] = {s_reg.a_out, s_reg.b_en,
                    s_reg.a_en, s_reg.b_edge, s_reg.a_edge, s_reg.mode};
                `TMR_ADR_IRQ_CTRL: s_next.rdata[7:0] = {s_reg.irq_en, s_reg.pending};
                `TMR_ADR_IRQ_LINES: s_next.rdata[15:0] = {line_two_num, line_one_num};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes; software has the last word on the counters
        // and on the pin A level.
        if (wr && sel_i[0]) begin
            unique case (adr_i[7:2])
                `TMR_ADR_PRESCALE: s_next.prescale = dat_i[`TMR_PS_W-1:0];
                `TMR_ADR_CLKSRC: begin
                    s_next.cs_one = dat_i[`TMR_CS1_LSB +: `TMR_CS_W];
                    s_next.cs_two = dat_i[`TMR_CS2_LSB +: `TMR_CS_W];
                end
                `TMR_ADR_MODE_CTRL: begin
                    s_next.mode = dat_i[`TMR_MC_MODE_LSB +: 2];
                    s_next.a_edge = dat_i[`TMR_MC_A_EDGE];
                    s_next.b_edge = dat_i[`TMR_MC_B_EDGE];
                    s_next.a_en = dat_i[`TMR_MC_A_EN];
                    s_next.b_en = dat_i[`TMR_MC_B_EN];
                    s_next.a_out = dat_i[`TMR_MC_A_OUT];
                end
                `TMR_ADR_IRQ_CTRL: begin
                    s_next.irq_en = dat_i[`TMR_IC_IEN_LSB +: 4];
                    sw_set = dat_i[`TMR_IC_PEND_LSB +: 4];
                end
                `TMR_ADR_IRQ_CLEAR: clr = dat_i[3:0];
                default: begin
                end
            endcase
        end
        if (wr) begin
            unique case (adr_i[7:2])
                `TMR_ADR_CNT_ONE: s_next.counter_one = put16(s_reg.counter_one, dat_i, sel_i);
                `TMR_ADR_CNT_TWO: s_next.counter_two = put16(s_reg.counter_two, dat_i, sel_i);
                `TMR_ADR_REG_A: s_next.reg_a = put16(s_reg.reg_a, dat_i, sel_i);
                `TMR_ADR_REG_B: s_next.reg_b = put16(s_reg.reg_b, dat_i, sel_i);
                default: begin
                end
            endcase
        end

        // Pending flags: events set regardless of enable and beat
        // a clear; writing zero never clears.
        s_next.pending = ((s_reg.pending | sw_set) & ~clr) | events;
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign dat_o = s_reg.rdata;
    assign ack_o = s_reg.ack;
    assign pin_a_o = s_reg.a_out;
    assign pin_a_oe_n_o = !a_drive;

    // Group the sources onto the two lines.
    assign irq_one_o = |(s_reg.pending[2:0] & s_reg.irq_en[2:0]);
    assign irq_two_o = s_reg.pending[3] && s_reg.irq_en[3];

endmodule : dual_timer

`default_nettype wire

// ### test/dual_timer_props.sv
// Checks on the dual timer's ports.
`default_nettype none

module dual_timer_props #(
    parameter bit UNIT_TWO = 1'b0 // Second unit.
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset.
    input wire logic ce_i, // Clock enable.
    input wire logic cyc_i, // Bus cycle.
    input wire logic stb_i, // Bus strobe.
    input wire logic we_i, // Bus write enable.
    input wire logic [7:0] adr_i, // Byte address.
    input wire logic [3:0] sel_i, // Byte lanes.
    input wire logic [31:0] dat_i, // Write data.
    input wire logic [31:0] dat_o, // Read data.
    input wire logic ack_o, // Acknowledge.
    input wire logic pin_a_o, // Pin A drive level.
    input wire logic pin_a_oe_n_o, // Pin A enable, low while driving.
    input wire logic irq_one_o, // Interrupt line one.
    input wire logic irq_two_o // Interrupt line two.
);
    localparam logic [15:0] LINES = UNIT_TWO ? 16'h0A0B : 16'h0C0D;

    typedef struct packed {
        logic [1:0] mode;
        logic a_en;
        logic [3:0] ien;
        logic [2:0] cs_two;
    } shadow_s;

    shadow_s sh_reg;
    shadow_s sh_next;
    logic wr_hit;

    // ---------------------------------------------------------------
    // Shadow of control fields from acked writes.
    // ---------------------------------------------------------------
    assign wr_hit = cyc_i && stb_i && we_i && ack_o && ce_i && sel_i[0];

    // Next shadow value; reset clears it.
    always_comb begin
        sh_next = sh_reg;
        if (wr_hit && adr_i[7:2] == 6'h06) begin
            sh_next.mode = dat_i[1:0];
            sh_next.a_en = dat_i[4];
        end
        if (wr_hit && adr_i[7:2] == 6'h07) begin
            sh_next.ien = dat_i[7:4];
        end
        if (wr_hit && adr_i[7:2] == 6'h01) begin
            sh_next.cs_two = dat_i[5:3];
        end
        if (rst_i) begin
            sh_next = '0;
        end
    end

    // Shadow register, frozen while ce_i is low.
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            sh_reg <= sh_next;
        end
    end

    // ---------------------------------------------------------------
    // Assertions.
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence

    chk_ack_single: assert property (s_req |=> s_ans)
        else $error("ack is not one pulse");
    chk_pin_level: assert property (
        wr_hit && adr_i[7:2] == 6'h06 |=> pin_a_o == $past(dat_i[6]))
        else $error("pin A level wrong after write");
    chk_pin_enable: assert property (
        pin_a_oe_n_o == !(sh_reg.a_en && sh_reg.mode != 2'h1))
        else $error("pin A drive enable wrong");
    chk_line_one_gate: assert property (irq_one_o |-> |sh_reg.ien[2:0])
        else $error("line one up while disabled");
    chk_line_two_gate: assert property (irq_two_o |-> sh_reg.ien[3])
        else $error("line two up while disabled");
    chk_clear_drops: assert property (
        wr_hit && adr_i[7:2] == 6'h08 && dat_i[3] && sh_reg.cs_two == 3'h0 |=> !irq_two_o)
        else $error("line two up after clear");
    chk_line_numbers: assert property (
        cyc_i && stb_i && !ack_o && ce_i && !we_i && adr_i[7:2] == 6'h09
        |=> dat_o[15:0] == LINES)
        else $error("line number register reads wrong");
    chk_prescale_width: assert property (
        cyc_i && stb_i && !ack_o && ce_i && !we_i && adr_i[7:2] == 6'h00
        |=> dat_o[31:5] == 27'h0)
        else $error("prescaler upper bits set");
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_i && ce_i |=> !irq_one_o && !irq_two_o && pin_a_oe_n_o && !ack_o)
        else $error("outputs not quiet after reset");
endmodule : dual_timer_props

bind dual_timer dual_timer_props #(.UNIT_TWO(UNIT_TWO)) props_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_a_o(pin_a_o),
    .pin_a_oe_n_o(pin_a_oe_n_o), .irq_one_o(irq_one_o), .irq_two_o(irq_two_o));

`default_nettype wire

// ### test/timer_pins_model.sv
// Model of what drives the timer pins and the slow clock.
`default_nettype none

module timer_pins_model (
    input wire logic clk_i, // System clock.
    input wire logic pin_a_o, // Level the timer drives on pin A.
    input wire logic pin_a_oe_n_o, // Low while the timer drives pin A.
    output logic pin_a_i, // Resolved level on pin A.
    output logic pin_b_i, // Level on pin B.
    output logic slow_clk_i // Slow clock, still outside pulses.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a_lvl = 1'b0, b_lvl = 1'b0, s_lvl = 1'b0;

    // Pin A follows the timer while driven.
    assign pin_a_i = pin_a_oe_n_o ? a_lvl : pin_a_o;
    assign pin_b_i = b_lvl;
    assign slow_clk_i = s_lvl;

    // n pulses on one line, two clocks per level.
    task automatic pulse(input int which, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clk_i);
            case (which)
                0: a_lvl <= ~a_lvl;
                1: b_lvl <= ~b_lvl;
                default: s_lvl <= ~s_lvl;
            endcase
            @(posedge clk_i);
        end
    endtask : pulse
endmodule : timer_pins_model

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the dual timer.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, pin_a_i, pin_a_o, pin_a_oe_n_o, pin_b_i, slow_clk_i, irq_one_o, irq_two_o;
    int num_errors = 0, checked = 0;
    int g1, g2;

    dual_timer dual_timer_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .pin_a_i(pin_a_i), .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o),
        .pin_b_i(pin_b_i), .slow_clk_i(slow_clk_i), .irq_one_o(irq_one_o), .irq_two_o(irq_two_o));
    timer_pins_model timer_pins_model_i (.clk_i(clk_i), .pin_a_o(pin_a_o),
        .pin_a_oe_n_o(pin_a_oe_n_o), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i), .slow_clk_i(slow_clk_i));

    // ---------------------------------------------------------------
    // Bus and comparison tasks.
    // ---------------------------------------------------------------
    // One classic cycle, held until ack is sampled.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus

    task automatic compare(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, e);
        end
    endtask : compare

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        compare(rd, e);
    endtask : expect_rd

    // Compares both lines a clock later.
    task automatic lines(input logic [31:0] e);
        @(posedge clk_i);
        compare({30'h0, irq_two_o, irq_one_o}, e);
    endtask : lines

    // Clocks until pin A changes, at most 400.
    task automatic gap(output int n);
        logic p;
        p = pin_a_o;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pin_a_o === p && n < 400);
    endtask : gap

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // ---------------------------------------------------------------
    // Clock, watchdog and test sequence.
    // ---------------------------------------------------------------
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Ends a hang.
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_rd(8'h00, 32'h0);
        expect_rd(8'h04, 32'h0);
        expect_rd(8'h1C, 32'h0);
        expect_rd(8'h24, 32'h0C0D);
        expect_rd(8'h3C, 32'h0);
        wr(8'h00, 32'hFF);
        expect_rd(8'h00, 32'h1F);
        wr(8'h04, 32'h3F);
        expect_rd(8'h04, 32'h3F);
        wr(8'h04, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(8'h18, 32'(m));
            expect_rd(8'h18, 32'(m));
        end
        $display("Test registers done");
        // Mode 1: reloads alternate A and B.
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h5);
        wr(8'h08, 32'h0);
        wr(8'h18, 32'h50);
        lines(32'h0);
        compare({31'h0, pin_a_o}, 32'h1);
        wr(8'h1C, 32'hF0);
        for (int p = 0; p < 5; p += 4) begin
            wr(8'h00, 32'(p));
            wr(8'h04, 32'h1);
            gap(g1);
            gap(g1);
            gap(g2);
            compare(32'(g1 + g2), 32'(10 * (p + 1)));
            wr(8'h04, 32'h0);
        end
        repeat (2) @(posedge clk_i);
        gap(g1);
        compare(32'(g1), 32'h190);
        expect_rd(8'h1C, 32'hF3);
        lines(32'h1);
        wr(8'h1C, 32'hF0);
        expect_rd(8'h1C, 32'hF3);
        wr(8'h1C, 32'h00);
        lines(32'h0);
        wr(8'h20, 32'h3);
        expect_rd(8'h1C, 32'h0);
        wr(8'h1C, 32'h88);
        lines(32'h2);
        wr(8'h20, 32'h8);
        expect_rd(8'h1C, 32'h80);
        $display("Test pulse done");
        // Mode 2: captures and underflow C.
        wr(8'h1C, 32'h0);
        wr(8'h18, 32'h1D);
        wr(8'h08, 32'h1234);
        timer_pins_model_i.pulse(0, 1);
        expect_rd(8'h10, 32'h1234);
        expect_rd(8'h08, 32'hFFFF);
        wr(8'h08, 32'h42);
        timer_pins_model_i.pulse(1, 1);
        expect_rd(8'h14, 32'h42);
        expect_rd(8'h08, 32'h42);
        expect_rd(8'h1C, 32'h3);
        wr(8'h20, 32'hF);
        wr(8'h08, 32'h2);
        wr(8'h04, 32'h1);
        repeat (60) @(posedge clk_i);
        wr(8'h04, 32'h0);
        expect_rd(8'h1C, 32'h4);
        wr(8'h20, 32'hF);
        $display("Test capture done");
        // Mode 4: pin B captures counter two.
        wr(8'h18, 32'h2B);
        wr(8'h0C, 32'h77);
        wr(8'h04, 32'h20);
        timer_pins_model_i.pulse(1, 1);
        expect_rd(8'h14, 32'h77);
        expect_rd(8'h0C, 32'hFFFF);
        expect_rd(8'h1C, 32'h2);
        // Mode 1: slow and event clocks.
        wr(8'h18, 32'h0);
        wr(8'h0C, 32'h5);
        timer_pins_model_i.pulse(2, 3);
        expect_rd(8'h0C, 32'h2);
        wr(8'h04, 32'h10);
        timer_pins_model_i.pulse(1, 2);
        expect_rd(8'h0C, 32'h0);
        wr(8'h04, 32'h0);
        $display("Test clocks done");
        // Mode 3: counter two reload raises D only.
        wr(8'h18, 32'h2);
        wr(8'h14, 32'h2);
        wr(8'h0C, 32'h0);
        wr(8'h20, 32'hF);
        wr(8'h1C, 32'h80);
        wr(8'h04, 32'h8);
        for (int i = 0; i < 200 && irq_two_o !== 1'b1; i++) @(posedge clk_i);
        wr(8'h04, 32'h0);
        expect_rd(8'h1C, 32'h88);
        $display("Test dual done");
        close_out();
    end
endmodule : tb

`default_nettype wire
